// file: core/rfi_core.sv
// Indirect access to the descriptor RAM with ECC fault injection and error logging
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module rfi_core
  import rfi_pkg::*;
#(
  parameter int LOCK_CLKS = LOCK_TIMEOUT_CLKS,
  parameter logic [31:0] DESC_BASE = 32'h0000_0000
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rfi_mreq_t m_req,
  output logic [63:0] m_rdata,
  output logic m_rvalid,
  output logic periph_correctable_flag,
  output logic fault_ecc_event,
  output logic fault_access_event
);
  localparam int LCW = $clog2(LOCK_CLKS + 1);

  // How the block runs, counted in pclk edges:
  //   APB read data is latched at the setup edge, so prdata already stands
  //   in the access cycle and pready can stay high; writes land at the
  //   access edge. An address outside the map answers with pslverr.
  //   A go write at edge E starts the slot move. The capture words or the
  //   array take the slot at E+2, go reads low from then on, and the access
  //   pulse stands for the one cycle after E+2.
  //   A master request taken at edge M is answered by m_rvalid, m_rdata and
  //   the ECC pulse in the cycle after M; m_rdata then holds until the next read.
  // Register fields:
  //   Select holds the row in [5:0] and the array in [21:16]. Control bit 0
  //   is the direction (1 reads), enable bit 0 is go, status bit 0 shows
  //   reads open and bit 1 writes open. Key registers read back as 0.
  //   The log status word carries valid in bit 31, cleared by writing a one,
  //   and the syndrome in [7:0]; the log address word is base plus row * 8.
  //   Staging and capture words 3 and 4 sit in the map but hold nothing.
  // Check code:
  //   Every protected bit owns a column of weight 3 or 5, data bits first,
  //   then row bits 0..5, which are byte offset bits 3..8. One flipped data
  //   bit leaves exactly its own column as the syndrome; one flipped check
  //   bit leaves a syndrome of weight one. Anything else is not corrected.
  // Limitations worth knowing:
  //   The array has no reset, so a master read of a slot never written
  //   returns unknown data and an unknown syndrome; fill slots first.
  //   The log has one entry. While it is valid every newer error is dropped,
  //   not only its exact repeat, which keeps the compare logic small.
  //   The idle timer of each direction restarts while go is high and on every write to its own key register.
  //   Master writes to a selected array vanish without any event, and a
  //   master write in the cycle an indirect write lands is dropped as well.
  //   A go write while an access is running is ignored, not queued.
  //   Locked-out master reads return a scrambler pattern, never array data.
  //   Check-bit-only errors are logged like data errors but need no fix.

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [71:0] mem [SLOTS];
  logic dir, next_dir;
  logic go, next_go;
  logic [1:0] go_cnt, next_go_cnt;
  logic [ARR_W-1:0] arr, next_arr;
  logic [ROW_W-1:0] row, next_row;
  rfi_lock_t lock_st [2];
  rfi_lock_t next_lock_st [2];
  logic [LCW-1:0] lock_cnt [2];
  logic [LCW-1:0] next_lock_cnt [2];
  logic [31:0] wstg [3];
  logic [31:0] next_wstg [3];
  logic [31:0] rcap [3];
  logic [31:0] next_rcap [3];
  logic ce_vld, next_ce_vld;
  logic [7:0] ce_syn, next_ce_syn;
  logic [ROW_W-1:0] ce_row, next_ce_row;
  logic [31:0] next_prdata;
  logic [63:0] next_m_rdata;
  logic next_m_rvalid;
  logic next_ecc_ev, next_acc_ev;
  logic [31:0] lfsr, next_lfsr;
  logic mem_we;
  logic [ROW_W-1:0] mem_wrow;
  logic [71:0] mem_wd;

  // Decode helpers
  logic wr_acc, rd_setup, sel_desc, hit, ima_done;
  logic [71:0] mw, iw;
  logic [7:0] syn;
  logic [63:0] fixd;
  logic [63:0] bit_hit;
  logic ce;
  logic ce_take;
  logic [31:0] kdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every transfer completes in its first access cycle
  // Zero wait states are safe because read data is latched a cycle early
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign periph_correctable_flag = ce_vld;

  always_comb
  begin
    case (paddr)
      OFF_CTRL, OFF_EN, OFF_STAT, OFF_SEL, OFF_WKEY, OFF_RKEY,
      OFF_WSTG0, OFF_WSTG1, OFF_WSTG2, OFF_WSTG3, OFF_WSTG4,
      OFF_RCAP0, OFF_RCAP1, OFF_RCAP2, OFF_RCAP3, OFF_RCAP4,
      OFF_CE_STS, OFF_CE_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master-side ECC check, combinational on the addressed slot
  always_comb
  begin
    mw = mem[m_req.row];
    iw = mem[row];
  end

  // Address part of the code cancels, so a data flip yields its column
  assign syn = mw[71:64] ^ rfi_ecc(mw[63:0], m_req.row);

  // One comparator per data bit: a syndrome equal to its column names it
  for (genvar b = 0; b < 64; b++)
  begin : g_bit_fix
    assign bit_hit[b] = (syn == rfi_col(b));
  end

  // Only the returned copy is fixed; the array keeps the flip
  assign fixd = mw[63:0] ^ bit_hit;
  // Check-bit flips have weight one and are correctable as well
  assign ce = ($countones(syn) == 1) || (bit_hit != 64'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, lock machines, access engine and log
  always_comb
  begin
    next_dir = dir;
    next_go = go;
    next_go_cnt = go_cnt;
    next_arr = arr;
    next_row = row;
    next_lock_st = lock_st;
    next_lock_cnt = lock_cnt;
    next_wstg = wstg;
    next_rcap = rcap;
    next_ce_vld = ce_vld;
    next_ce_syn = ce_syn;
    next_ce_row = ce_row;
    next_prdata = prdata;
    next_m_rdata = m_rdata;
    next_m_rvalid = 1'b0;
    next_ecc_ev = 1'b0;
    next_acc_ev = 1'b0;
    ce_take = 1'b0;
    next_lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    mem_we = 1'b0;
    mem_wrow = m_req.row;
    mem_wd = {rfi_ecc(m_req.wdata, m_req.row), m_req.wdata};
    kdata = pwdata;
    wr_acc = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    sel_desc = (arr == DESC_ARRAY); // Zero select frees the RAM
    ima_done = go & (go_cnt == 2'd1);

    // Read data is latched in the setup cycle, so it is ready at access
    if (rd_setup)
    begin
      case (paddr)
        OFF_CTRL: next_prdata = 32'(dir) << DIR_BIT;
        OFF_EN: next_prdata = 32'(go) << GO_BIT;
        OFF_STAT: next_prdata = (32'(lock_st[0] == RFI_OPEN) << RD_OPEN_BIT)
          | (32'(lock_st[1] == RFI_OPEN) << WR_OPEN_BIT);
        OFF_SEL: next_prdata = (32'(arr) << ARR_LSB) | (32'(row) << ROW_LSB);
        OFF_WSTG0: next_prdata = wstg[0];
        OFF_WSTG1: next_prdata = wstg[1];
        OFF_WSTG2: next_prdata = wstg[2];
        OFF_RCAP0: next_prdata = rcap[0];
        OFF_RCAP1: next_prdata = rcap[1];
        OFF_RCAP2: next_prdata = rcap[2];
        OFF_CE_STS: next_prdata = (32'(ce_vld) << VALID_BIT) | 32'(ce_syn);
        OFF_CE_ADDR: next_prdata = DESC_BASE + {23'h0, ce_row, 3'b000};
        default: next_prdata = 32'h0000_0000; // Words 3,4 unused here
      endcase
    end

    // Lock timeout: an open direction with no go for too long closes
    for (int d = 0; d < 2; d++)
    begin
      if (lock_st[d] == RFI_OPEN && !go)
      begin
        if (lock_cnt[d] == LCW'(LOCK_CLKS - 1))
        begin
          next_lock_st[d] = RFI_LOCKED;
          next_lock_cnt[d] = '0;
        end
        else
          next_lock_cnt[d] = lock_cnt[d] + 1'b1;
      end
      else
        next_lock_cnt[d] = '0;
    end

    // Self-clearing go, two clocks from the write that set it
    if (go)
    begin
      next_go_cnt = go_cnt - 1'b1;
      if (ima_done)
      begin
        next_go = 1'b0;
        next_acc_ev = 1'b1;
        if (dir)
        begin
          next_rcap[0] = iw[31:0]; // Second data word
          next_rcap[1] = iw[63:32]; // First data word
          next_rcap[2] = {24'h000000, iw[71:64]};
        end
        else
        begin
          mem_we = 1'b1;
          mem_wrow = row;
          mem_wd = {wstg[2][7:0], wstg[1], wstg[0]}; // Raw ECC kept
        end
      end
    end

    // Register writes take effect in the access cycle
    if (wr_acc)
    begin
      case (paddr)
        OFF_CTRL: next_dir = pwdata[DIR_BIT];
        OFF_EN:
        begin
          // Go only with that direction open and the RAM selected
          if (pwdata[GO_BIT] && !go && sel_desc
              && lock_st[dir ? 0 : 1] == RFI_OPEN)
          begin
            next_go = 1'b1;
            next_go_cnt = 2'(GO_CLKS);
          end
        end
        OFF_SEL:
        begin
          next_arr = pwdata[ARR_LSB +: ARR_W];
          next_row = pwdata[ROW_LSB +: ROW_W];
        end
        OFF_RKEY:
        begin
          if (kdata == RKEY1)
            next_lock_st[0] = RFI_KEY1;
          else if (lock_st[0] == RFI_KEY1 && kdata == RKEY2)
            next_lock_st[0] = RFI_OPEN;
          else
            next_lock_st[0] = RFI_LOCKED;
          next_lock_cnt[0] = '0;
        end
        OFF_WKEY:
        begin
          if (kdata == WKEY1)
            next_lock_st[1] = RFI_KEY1;
          else if (lock_st[1] == RFI_KEY1 && kdata == WKEY2)
            next_lock_st[1] = RFI_OPEN;
          else
            next_lock_st[1] = RFI_LOCKED;
          next_lock_cnt[1] = '0;
        end
        OFF_WSTG0: next_wstg[0] = pwdata;
        OFF_WSTG1: next_wstg[1] = pwdata;
        OFF_WSTG2: next_wstg[2] = pwdata;
        OFF_CE_STS:
          if (pwdata[VALID_BIT])
            next_ce_vld = 1'b0; // Write one clears; a new record below wins
        default: ;
      endcase
    end

    // Other masters: locked out while the RAM is selected
    if (m_req.valid)
    begin
      if (m_req.write)
      begin
        // A finishing indirect write owns the port; never cancel it here
        if (!sel_desc && !ima_done)
          mem_we = 1'b1;
      end
      else
      begin
        next_m_rvalid = 1'b1;
        if (sel_desc)
          next_m_rdata = {lfsr, ~lfsr};
        else
        begin
          next_m_rdata = fixd;
          if (syn != 8'h00)
          begin
            next_ecc_ev = 1'b1;
            // One entry only: a live entry blocks any newer error, its exact
            // repeat included; a clear in this same cycle loses to the set
            ce_take = ce && !next_ce_vld;
            if (ce_take)
            begin
              next_ce_vld = 1'b1;
              next_ce_row = m_req.row;
              next_ce_syn = syn;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM array: no reset, contents survive like a real macro
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_wrow] <= mem_wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  // Reset closes both directions and frees the array; the array keeps data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir <= 1'b0;
      go <= 1'b0;
      go_cnt <= 2'd0;
      arr <= ARR_RESET;
      row <= ROW_RESET;
      lock_st <= '{RFI_LOCKED, RFI_LOCKED};
      lock_cnt <= '{'0, '0};
      wstg <= '{32'h0, 32'h0, 32'h0};
      rcap <= '{32'h0, 32'h0, 32'h0};
      ce_vld <= 1'b0;
      ce_syn <= 8'h00;
      ce_row <= '0;
      prdata <= 32'h0000_0000;
      m_rdata <= 64'h0;
      m_rvalid <= 1'b0;
      fault_ecc_event <= 1'b0;
      fault_access_event <= 1'b0;
      lfsr <= LFSR_SEED;
    end
    else
    begin
      dir <= next_dir;
      go <= next_go;
      go_cnt <= next_go_cnt;
      arr <= next_arr;
      row <= next_row;
      lock_st <= next_lock_st;
      lock_cnt <= next_lock_cnt;
      wstg <= next_wstg;
      rcap <= next_rcap; // Held until the next finished read
      ce_vld <= next_ce_vld;
      ce_syn <= next_ce_syn;
      ce_row <= next_ce_row;
      prdata <= next_prdata;
      m_rdata <= next_m_rdata;
      m_rvalid <= next_m_rvalid;
      fault_ecc_event <= next_ecc_ev;
      fault_access_event <= next_acc_ev;
      lfsr <= next_lfsr;
    end
  end
endmodule : rfi_core

// file: core/rfi_pkg.sv
// Package: register map, keys, ECC code and carrier types for RAM fault injection
package rfi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EN = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_SEL = 8'h0c;
  localparam logic [7:0] OFF_WKEY = 8'h10;
  localparam logic [7:0] OFF_RKEY = 8'h14;
  localparam logic [7:0] OFF_WSTG4 = 8'h2c;
  localparam logic [7:0] OFF_WSTG3 = 8'h30;
  localparam logic [7:0] OFF_WSTG2 = 8'h34;
  localparam logic [7:0] OFF_WSTG1 = 8'h38;
  localparam logic [7:0] OFF_WSTG0 = 8'h3c;
  localparam logic [7:0] OFF_RCAP4 = 8'h4c;
  localparam logic [7:0] OFF_RCAP3 = 8'h50;
  localparam logic [7:0] OFF_RCAP2 = 8'h54;
  localparam logic [7:0] OFF_RCAP1 = 8'h58;
  localparam logic [7:0] OFF_RCAP0 = 8'h5c;
  localparam logic [7:0] OFF_CE_STS = 8'h60;
  localparam logic [7:0] OFF_CE_ADDR = 8'h64;
  // Field positions
  localparam int DIR_BIT = 0;
  localparam int GO_BIT = 0;
  localparam int RD_OPEN_BIT = 0;
  localparam int WR_OPEN_BIT = 1;
  localparam int ROW_LSB = 0;
  localparam int ROW_W = 6;
  localparam int ARR_LSB = 16;
  localparam int ARR_W = 6;
  localparam int VALID_BIT = 31;
  localparam int SLOTS = 64;
  localparam logic [ARR_W-1:0] DESC_ARRAY = 6'h02;
  localparam logic [ARR_W-1:0] ARR_RESET = 6'h00;
  localparam logic [ROW_W-1:0] ROW_RESET = 6'h00;
  // Unlock keys
  localparam logic [31:0] RKEY1 = 32'hf06ab5bc;
  localparam logic [31:0] RKEY2 = 32'h14081b56;
  localparam logic [31:0] WKEY1 = 32'h04a43f95;
  localparam logic [31:0] WKEY2 = 32'he4a9ebf7;
  // Timing, in system clocks
  localparam int GO_CLKS = 2;
  localparam int LOCK_TIMEOUT_CLKS = 16384;
  localparam logic [31:0] LFSR_SEED = 32'hace1_2461;

  typedef enum logic [1:0] {
    RFI_LOCKED = 2'b00,
    RFI_KEY1 = 2'b01,
    RFI_OPEN = 2'b10
  } rfi_lock_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ROW_W-1:0] row;
    logic [63:0] wdata;
  } rfi_mreq_t;

  // Column code of one protected bit: distinct odd weight 3 or 5
  function automatic logic [7:0] rfi_col(input int idx);
    int n;
    logic [7:0] v;
    n = 0;
    rfi_col = 8'h00;
    for (int k = 7; k < 256; k++)
    begin
      v = 8'(k);
      if ($countones(v) == 3 || $countones(v) == 5)
      begin
        if (n == idx)
          rfi_col = v;
        n++;
      end
    end
  endfunction : rfi_col

  // Check bits over data and slot byte offset bits 3..8 only
  function automatic logic [7:0] rfi_ecc(input logic [63:0] d, input logic [ROW_W-1:0] row);
    rfi_ecc = 8'h00;
    for (int i = 0; i < 64; i++)
      if (d[i])
        rfi_ecc ^= rfi_col(i);
    for (int j = 0; j < ROW_W; j++)
      if (row[j])
        rfi_ecc ^= rfi_col(64 + j);
  endfunction : rfi_ecc
endpackage : rfi_pkg

// file: test/rfi_core_bench.sv
// Self-checking bench for the RAM fault injection block
`timescale 1ns/1ps
module rfi_core_bench
  import rfi_pkg::*;
;
  localparam int LOCK = 32;
  localparam logic [31:0] BASE = 32'h0000_5000;
  localparam logic [63:0] D = 64'h0000_0003_0000_0004;
  localparam logic [63:0] D2 = 64'h1234_5678_9abc_def0;
  localparam logic [63:0] MASK = 64'h4000_0000_0000_0000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rfi_mreq_t m_req;
  logic [63:0] m_rdata;
  logic m_rvalid;
  logic periph_correctable_flag;
  logic fault_ecc_event;
  logic fault_access_event;
  logic err;
  logic [31:0] r;
  logic [63:0] q;
  logic ev;
  logic ok;
  int mismatches = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 pclk = ~pclk;
  // Design and far-side master
  rfi_core #(.LOCK_CLKS(LOCK), .DESC_BASE(BASE)) rfi_core_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_req(m_req), .m_rdata(m_rdata),
    .m_rvalid(m_rvalid), .periph_correctable_flag(periph_correctable_flag),
    .fault_ecc_event(fault_ecc_event), .fault_access_event(fault_access_event));
  rfi_master_model rfi_master_model_i (.pclk(pclk), .m_req(m_req), .m_rdata(m_rdata),
    .m_rvalid(m_rvalid), .fault_ecc_event(fault_ecc_event));
  ////////////////////////////////////////////////////////////////////////////////
  // Own check-bit model: columns of weight 3 or 5, data then row bits
  function automatic logic [7:0] code(input logic [63:0] d, input logic [5:0] row);
    int n;
    n = 0;
    code = 8'h00;
    for (int k = 7; k < 256; k++)
      if ($countones(8'(k)) == 3 || $countones(8'(k)) == 5)
      begin
        if (n < 64 && d[n])
          code ^= 8'(k);
        else if (n >= 64 && n < 70 && row[n - 64])
          code ^= 8'(k);
        n++;
      end
  endfunction : code
  // Verdict and end of run
  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // APB transfer; request held until pready is seen, bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_v);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      mismatches++;
      wrap_up();
    end
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask : rd
  task automatic unlock(input logic dir);
    wr(dir ? OFF_RKEY : OFF_WKEY, dir ? RKEY1 : WKEY1);
    wr(dir ? OFF_RKEY : OFF_WKEY, dir ? RKEY2 : WKEY2);
  endtask : unlock
  // Whole indirect access: unlock, select, go, watch go clear, deselect
  task automatic indirect_memory_access(input logic dir, input logic [5:0] row);
    logic [31:0] x;
    unlock(dir);
    rd(OFF_STAT, x);
    chk(x[dir ? RD_OPEN_BIT : WR_OPEN_BIT], 1'b1);
    wr(OFF_SEL, {10'h000, DESC_ARRAY, 10'h000, row});
    wr(OFF_CTRL, {31'h0, dir});
    wr(OFF_EN, 32'h1);
    rd(OFF_EN, x);
    chk(x[GO_BIT], 1'b1);
    rd(OFF_EN, x);
    chk(x[GO_BIT], 1'b0);
    wr(OFF_SEL, 32'h0);
  endtask : indirect_memory_access
  // Master read through the partner; a missing answer ends the run
  task automatic mread(input logic [5:0] row);
    rfi_master_model_i.mrd(row, q, ev, ok);
    if (ok !== 1'b1)
    begin
      mismatches++;
      wrap_up();
    end
  endtask : mread
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STAT, r);
    chk(r, 32'h0);
    rd(OFF_SEL, r);
    chk(r, 32'h0);
    rd(8'h18, r);
    chk(err, 1'b1);
    rfi_master_model_i.send(1'b1, 6'd1, D);
    rfi_master_model_i.send(1'b1, 6'd2, D2);
    // Capture layout and address-covering check bits
    indirect_memory_access(1'b1, 6'd1);
    rd(OFF_RCAP0, r);
    chk(r, D[31:0]);
    rd(OFF_RCAP1, r);
    chk(r, D[63:32]);
    rd(OFF_RCAP2, r);
    chk(r, {24'h0, code(D, 6'd1)});
    rd(OFF_RCAP3, r);
    chk(r, 32'h0);
    rd(OFF_RCAP4, r);
    chk(r, 32'h0);
    // Inject one data bit, keep old check bits
    wr(OFF_WSTG0, D[31:0]);
    wr(OFF_WSTG1, D[63:32] ^ MASK[63:32]);
    wr(OFF_WSTG2, {24'h0, code(D, 6'd1)});
    indirect_memory_access(1'b0, 6'd1);
    mread(6'd1);
    chk(q, D);
    chk(ev, 1'b1);
    chk(periph_correctable_flag, 1'b1);
    rd(OFF_CE_STS, r);
    chk(r[VALID_BIT], 1'b1);
    chk(r[7:0], code(MASK, 6'd1) ^ code(64'h0, 6'd1));
    rd(OFF_CE_ADDR, r);
    chk(r, BASE + 32'h8);
    // Stored word stays corrupted
    indirect_memory_access(1'b1, 6'd1);
    rd(OFF_RCAP1, r);
    chk(r, D[63:32] ^ MASK[63:32]);
    rd(OFF_RCAP2, r);
    chk(r, {24'h0, code(D, 6'd1)});
    // Repeat dropped while logged, logged again after clear
    mread(6'd1);
    chk(ev, 1'b1);
    rd(OFF_CE_STS, r);
    chk(r[7:0], code(MASK, 6'd1) ^ code(64'h0, 6'd1));
    wr(OFF_CE_STS, 32'h8000_0000);
    rd(OFF_CE_STS, r);
    chk({r[VALID_BIT], periph_correctable_flag}, 2'b00);
    mread(6'd1);
    chk(periph_correctable_flag, 1'b1);
    // Relock by wrong key and by idle timeout
    wr(OFF_RKEY, RKEY1);
    wr(OFF_RKEY, 32'h0);
    rd(OFF_STAT, r);
    chk(r[RD_OPEN_BIT], 1'b0);
    unlock(1'b1);
    repeat (LOCK + 4) @(posedge pclk);
    rd(OFF_STAT, r);
    chk(r[RD_OPEN_BIT], 1'b0);
    // Go refused while locked; other master shut out while selected
    wr(OFF_SEL, {10'h000, DESC_ARRAY, 10'h000, 6'd2});
    wr(OFF_CTRL, 32'h1);
    wr(OFF_EN, 32'h1);
    rd(OFF_EN, r);
    chk(r[GO_BIT], 1'b0);
    rfi_master_model_i.send(1'b1, 6'd2, ~D2);
    mread(6'd2);
    chk({ok, ev}, 2'b10);
    chk(q === D2, 1'b0);
    wr(OFF_SEL, 32'h0);
    mread(6'd2);
    chk(q, D2);
    rd(OFF_RCAP1, r);
    chk(r, D[63:32] ^ MASK[63:32]);
    wrap_up();
  end
endmodule : rfi_core_bench

bind rfi_core rfi_props #(.LOCK_CLKS(LOCK_CLKS), .DESC_BASE(DESC_BASE)) rfi_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .m_req(m_req), .m_rdata(m_rdata), .m_rvalid(m_rvalid),
  .periph_correctable_flag(periph_correctable_flag), .fault_ecc_event(fault_ecc_event),
  .fault_access_event(fault_access_event));

// file: test/rfi_core_properties.sv
// Port assertions for the RAM fault injection block
`timescale 1ns/1ps
module rfi_props
  import rfi_pkg::*;
#(
  parameter int LOCK_CLKS = LOCK_TIMEOUT_CLKS,
  parameter logic [31:0] DESC_BASE = 32'h0000_0000
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rfi_mreq_t m_req,
  input wire logic [63:0] m_rdata,
  input wire logic m_rvalid,
  input wire logic periph_correctable_flag,
  input wire logic fault_ecc_event,
  input wire logic fault_access_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Steps of a go request and of a master read
  sequence go_req;
    psel && penable && pwrite && paddr == OFF_EN && pwdata[GO_BIT];
  endsequence
  sequence mem_rd;
    m_req.valid && !m_req.write;
  endsequence
  // Access pulse lands exactly three edges after the go write
  chk_access_early: assert property (go_req |=> !fault_access_event [*2])
    else $error("access event came early");
  chk_access_cause: assert property (fault_access_event |->
    $past(psel && penable && pwrite && paddr == OFF_EN && pwdata[GO_BIT], 3))
    else $error("access event without go");
  chk_access_pulse: assert property (fault_access_event |=> !fault_access_event)
    else $error("access event too long");
  // Master port answers and error reporting
  chk_rd_answer: assert property (mem_rd |=> m_rvalid)
    else $error("master read not answered");
  chk_rvalid_cause: assert property (m_rvalid |-> $past(m_req.valid && !m_req.write))
    else $error("read valid without request");
  chk_ecc_evt_read: assert property (fault_ecc_event |-> m_rvalid)
    else $error("ecc event outside a read");
  chk_flag_rise: assert property ($rose(periph_correctable_flag) |-> fault_ecc_event)
    else $error("flag rose without ecc event");
  chk_flag_clear: assert property ($fell(periph_correctable_flag) |->
    $past(psel && penable && pwrite && paddr == OFF_CE_STS && pwdata[VALID_BIT]))
    else $error("flag fell without clear");
endmodule : rfi_props

// file: test/rfi_master_model.sv
// Model of another bus master using the descriptor RAM port
`timescale 1ns/1ps
module rfi_master_model
  import rfi_pkg::*;
(
  input wire logic pclk,
  output rfi_mreq_t m_req,
  input wire logic [63:0] m_rdata,
  input wire logic m_rvalid,
  input wire logic fault_ecc_event
);
  ////////////////////////////////////////////////////////////////////////////////
  // No request at time zero
  initial m_req = '0;
  // One-cycle request; released fields inverted so stale data never passes
  task automatic send(input logic wr, input logic [5:0] row, input logic [63:0] d);
    @(posedge pclk);
    m_req <= '{valid: 1'b1, write: wr, row: row, wdata: d};
    @(posedge pclk);
    m_req <= '{valid: 1'b0, write: 1'b0, row: ~row, wdata: ~d};
  endtask : send
  // Read a slot and wait a bounded time for its answer
  task automatic mrd(input logic [5:0] row, output logic [63:0] q, output logic ev,
                     output logic ok);
    send(1'b0, row, 64'h0);
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge pclk);
      ok = (m_rvalid === 1'b1);
    end
    q = m_rdata;
    ev = fault_ecc_event;
  endtask : mrd
endmodule : rfi_master_model
